// *** adtx_port_ctrl.sv ***
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "adtx_defs.svh"
module adtx_port_ctrl
  import adtx_pkg::*;
#(
  parameter int FRAME_CYC = `ADTX_FRAME_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  adc_result,
  input  wire logic        adc_valid,
  output adtx_ana_s        ana_ctrl,
  output logic             seq_clk,
  output logic             charge_pump_clk,
  input  wire logic        tx_bit_clock,
  input  wire logic        tx_frame_enable,
  output logic             tx_serial_out,
  output logic             tx_serial_oe
);

  // Core domain: register file and bus slave.
  logic [7:0]  main_ctrl_r;
  logic [2:0]  tx_gain_r;
  logic        delay_sel_r;
  logic [1:0]  conv_mode_r;
  logic [7:0]  monitor_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic        frame_lost_r;
  adtx_rate_e  last_rate_r;
  logic        wb_req;
  logic        wb_wr;
  logic        io_monitor;

  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_wr  = wb_req & wb_we_i & wb_sel_i[0];
  assign io_monitor =
    (main_ctrl_r[`ADTX_IO_MODE_MSB:`ADTX_IO_MODE_LSB] == `ADTX_IO_MODE_MON);

  // Answer every request one cycle after it is seen, mapped or not.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end
  assign wb_ack_o = ack_r;

  // Writable registers; only byte lane 0 carries fields.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      main_ctrl_r <= `ADTX_MAIN_CTRL_RST;
      tx_gain_r   <= `ADTX_TX_GAIN_RST;
      delay_sel_r <= `ADTX_DELAY_SEL_RST;
      conv_mode_r <= `ADTX_CONV_MODE_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        `ADTX_MAIN_CTRL_OFS:  main_ctrl_r <= wb_dat_i[7:0];
        `ADTX_TX_GAIN_OFS:    tx_gain_r <= wb_dat_i[2:0];
        `ADTX_TONE_DELAY_OFS: delay_sel_r <= wb_dat_i[`ADTX_DELAY_SEL_BIT];
        `ADTX_CONV_MODE_OFS: begin
          conv_mode_r <= {wb_dat_i[`ADTX_LINEAR_BIT],
                          wb_dat_i[`ADTX_HPF_BYPASS_BIT]};
        end
        default: ;
      endcase
    end
  end

  // Read data is registered; unmapped addresses read as zero.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      rdat_r <= 32'h0;
    end else if (wb_req && !wb_we_i) begin
      case (wb_adr_i)
        `ADTX_MAIN_CTRL_OFS:  rdat_r <= {24'h0, main_ctrl_r};
        `ADTX_TX_GAIN_OFS:    rdat_r <= {29'h0, tx_gain_r};
        `ADTX_TONE_DELAY_OFS: rdat_r <= {26'h0, delay_sel_r, 5'h0};
        `ADTX_CONV_MODE_OFS:  rdat_r <= {26'h0, conv_mode_r, 4'h0};
        `ADTX_MONITOR_OFS:    rdat_r <= {24'h0, monitor_r};
        `ADTX_STATUS_OFS:     rdat_r <= {29'h0, frame_lost_r, last_rate_r};
        default:              rdat_r <= 32'h0;
      endcase
    end
  end
  assign wb_dat_o = rdat_r;

  // Analog-side settings follow the registers directly.
  always_comb begin
    ana_ctrl.trim_gain      = tx_gain_r;
    ana_ctrl.hpf_bypass     = conv_mode_r[0];
    ana_ctrl.adc_linear     = conv_mode_r[1] | io_monitor;
    ana_ctrl.adc_sel_supply = io_monitor;
    ana_ctrl.pump_en        = main_ctrl_r[`ADTX_PUMP_EN_BIT];
  end

  // Converter results.
  logic [7:0] sample_r;
  // Monitor mode steers results to the monitor register, not the encoder.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      monitor_r <= 8'h00;
      sample_r  <= 8'h00;
    end else if (adc_valid) begin
      if (io_monitor) begin
        monitor_r <= adc_result;
      end else begin
        sample_r <= adc_result;
      end
    end
  end

  // Sequencing clock and charge pump.
  logic [9:0] seq_cnt_r;
  logic       seq_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      seq_cnt_r <= 10'h0;
      seq_r     <= 1'b0;
    end else if (seq_cnt_r == 10'(`ADTX_SEQ_HALF_CYC - 1)) begin
      seq_cnt_r <= 10'h0;
      seq_r     <= ~seq_r;
    end else begin
      seq_cnt_r <= seq_cnt_r + 10'h1;
    end
  end
  assign seq_clk = seq_r;
  assign charge_pump_clk = seq_r & main_ctrl_r[`ADTX_PUMP_EN_BIT];

  // Frame events from the link.
  logic       req_tgl_l;
  logic [3:0] meas_len_l;
  logic       req_s1_r;
  logic       req_s2_r;
  logic       req_d_r;
  logic       frame_evt;
  logic [2:0] req_dec;
  // Toggle crossing; the length word is written on the same edge as the toggle and is stable by the time the toggle has crossed.
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      req_d_r  <= 1'b0;
    end else begin
      req_s1_r <= req_tgl_l;
      req_s2_r <= req_s1_r;
      req_d_r  <= req_s2_r;
    end
  end
  assign frame_evt = req_s2_r ^ req_d_r;
  assign req_dec = adtx_len2rate(meas_len_l);

  // Encoder service and rate delay.
  adtx_rate_e rate_q_r [`ADTX_PIPE_DEPTH];
  adtx_word_s word_r;
  logic       word_tgl_r;
  adtx_rate_e enc_rate;
  adtx_rate_e new_rate;
  // Invalid lengths repeat the previous request rather than stall.
  assign new_rate = req_dec[2] ? adtx_rate_e'(req_dec[1:0]) : rate_q_r[0];
  assign enc_rate = delay_sel_r ? rate_q_r[`ADTX_DELAY_LONG]
                                : rate_q_r[`ADTX_DELAY_NORMAL];

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < `ADTX_PIPE_DEPTH; i++) begin
        rate_q_r[i] <= ADTX_R32;
      end
      last_rate_r <= ADTX_R32;
    end else if (frame_evt) begin
      rate_q_r[0] <= new_rate;
      for (int i = 1; i < `ADTX_PIPE_DEPTH; i++) begin
        rate_q_r[i] <= rate_q_r[i-1];
      end
      last_rate_r <= new_rate;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      word_r     <= '{rate: ADTX_R32, data: 8'h00};
      word_tgl_r <= 1'b0;
    end else if (frame_evt) begin
      word_r.rate <= enc_rate;
      // The current sample, never a delayed one, left aligned.
      word_r.data <= sample_r & (8'hFF << (4'h8 - adtx_rate_bits(enc_rate)));
      word_tgl_r  <= ~word_tgl_r;
    end
  end

  // Frame watchdog: no enable for a whole frame marks the link lost.
  logic [15:0] frame_cnt_r;
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      frame_cnt_r  <= 16'h0;
      frame_lost_r <= 1'b0;
    end else if (frame_evt) begin
      frame_cnt_r  <= 16'h0;
      frame_lost_r <= 1'b0;
    end else if (frame_cnt_r == 16'(FRAME_CYC)) begin
      frame_lost_r <= 1'b1;
    end else begin
      frame_cnt_r <= frame_cnt_r + 16'h1;
    end
  end

  // Link domain, clocked by tx_bit_clock.
  logic       lrst_s1_r;
  logic       lrst_n_r;
  logic       fe_s1_r;
  logic       fe_s2_r;
  logic       fe_d_r;
  logic [3:0] len_cnt_r;
  logic       wt_s1_r;
  logic       wt_s2_r;
  logic       wt_d_r;
  adtx_word_s hold_r;
  logic [7:0] shift_r;
  logic [3:0] bits_left_r;
  logic       drive_r;
  logic       cut_r;
  logic       fe_rise;
  logic       fe_fall;

  // Reset and enable each pass two flops in the link domain.
  always_ff @(posedge tx_bit_clock) begin
    lrst_s1_r <= reset_n;
    lrst_n_r  <= lrst_s1_r;
  end

  always_ff @(posedge tx_bit_clock) begin
    if (!lrst_n_r) begin
      fe_s1_r <= 1'b0;
      fe_s2_r <= 1'b0;
      fe_d_r  <= 1'b0;
    end else begin
      fe_s1_r <= tx_frame_enable;
      fe_s2_r <= fe_s1_r;
      fe_d_r  <= fe_s2_r;
    end
  end
  assign fe_rise = fe_s2_r & ~fe_d_r;
  assign fe_fall = ~fe_s2_r & fe_d_r;

  always_ff @(posedge tx_bit_clock) begin
    if (!lrst_n_r) begin
      len_cnt_r  <= 4'h0;
      meas_len_l <= 4'h0;
      req_tgl_l  <= 1'b0;
    end else if (fe_rise) begin
      len_cnt_r <= 4'h1;
    end else if (fe_fall) begin
      meas_len_l <= len_cnt_r;
      req_tgl_l  <= ~req_tgl_l;
    end else if (fe_s2_r && len_cnt_r != 4'hF) begin
      len_cnt_r <= len_cnt_r + 4'h1;
    end
  end

  // Word crossing: catch the encoder word when its toggle lands.
  always_ff @(posedge tx_bit_clock) begin
    if (!lrst_n_r) begin
      wt_s1_r <= 1'b0;
      wt_s2_r <= 1'b0;
      wt_d_r  <= 1'b0;
      hold_r  <= '{rate: ADTX_R32, data: 8'h00};
    end else begin
      wt_s1_r <= word_tgl_r;
      wt_s2_r <= wt_s1_r;
      wt_d_r  <= wt_s2_r;
      if (wt_s2_r ^ wt_d_r) begin
        hold_r <= word_r;
      end
    end
  end

  always_ff @(posedge tx_bit_clock) begin
    if (!lrst_n_r) begin
      shift_r     <= 8'h00;
      bits_left_r <= 4'h0;
      drive_r     <= 1'b0;
    end else if (fe_rise) begin
      shift_r     <= hold_r.data;
      bits_left_r <= adtx_rate_bits(hold_r.rate);
      drive_r     <= 1'b1;
    end else if (drive_r) begin
      shift_r     <= {shift_r[6:0], 1'b0};
      bits_left_r <= bits_left_r - 4'h1;
      drive_r     <= (bits_left_r != 4'h1);
    end
  end

  always_ff @(negedge tx_bit_clock) begin
    if (!lrst_n_r) begin
      cut_r <= 1'b0;
    end else begin
      cut_r <= drive_r && (bits_left_r == 4'h1);
    end
  end
  assign tx_serial_out = shift_r[7];
  assign tx_serial_oe  = drive_r & ~cut_r;

  // Assertions on the core and link sides.
  a_bus_ack_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
  a_trim_gain_write: assert property (@(posedge ref_clk)
    disable iff (!reset_n) wb_wr && wb_adr_i == `ADTX_TX_GAIN_OFS
    |=> ana_ctrl.trim_gain == $past(wb_dat_i[2:0]))
    else $error("trim gain not taken");
  a_hpf_bypass_write: assert property (@(posedge ref_clk)
    disable iff (!reset_n) wb_wr && wb_adr_i == `ADTX_CONV_MODE_OFS
    |=> ana_ctrl.hpf_bypass == $past(wb_dat_i[4]) ##1 $stable(ana_ctrl))
    else $error("filter bypass wrong");
  a_linear_mode: assert property (@(posedge ref_clk) disable iff (!reset_n)
    wb_wr && wb_adr_i == `ADTX_CONV_MODE_OFS |=> ana_ctrl.adc_linear ==
    ($past(wb_dat_i[5]) || ana_ctrl.adc_sel_supply))
    else $error("linear mode missing");
  a_monitor_result: assert property (@(posedge ref_clk)
    disable iff (!reset_n) adc_valid && ana_ctrl.adc_sel_supply
    |=> monitor_r == $past(adc_result) && $stable(sample_r))
    else $error("monitor result not stored");
  a_pump_clock_gate: assert property (@(posedge ref_clk)
    disable iff (!reset_n) !ana_ctrl.pump_en |-> !charge_pump_clk)
    else $error("pump clocked while off");
  a_rate_two_frame: assert property (@(posedge ref_clk)
    disable iff (!reset_n) frame_evt && !delay_sel_r
    |=> word_r.rate == $past(rate_q_r[0]))
    else $error("two frame rate wrong");
  a_rate_six_frame: assert property (@(posedge ref_clk)
    disable iff (!reset_n) frame_evt && delay_sel_r
    |=> word_r.rate == $past(rate_q_r[4]))
    else $error("six frame rate wrong");
  a_one_service: assert property (@(posedge ref_clk) disable iff (!reset_n)
    frame_evt |=> !frame_evt[*3]) else $error("double service");
  a_drive_min_len: assert property (@(posedge tx_bit_clock)
    disable iff (!lrst_n_r) fe_rise |=> drive_r[*2])
    else $error("word drive too short");
  a_len_decode: assert property (@(posedge tx_bit_clock)
    disable iff (!lrst_n_r) fe_fall && len_cnt_r == 4'h8
    |=> meas_len_l == 4'h8 && $changed(req_tgl_l))
    else $error("enable length lost");
endmodule

// *** adtx_defs.svh ***
`ifndef ADTX_DEFS_SVH
`define ADTX_DEFS_SVH

// Register byte offsets on the Wishbone slave.
`define ADTX_MAIN_CTRL_OFS   8'h00
`define ADTX_TX_GAIN_OFS     8'h04
`define ADTX_TONE_DELAY_OFS  8'h1C
`define ADTX_CONV_MODE_OFS   8'h20
`define ADTX_MONITOR_OFS     8'h24
`define ADTX_STATUS_OFS      8'h28

// Field positions.
`define ADTX_PUMP_EN_BIT     0
`define ADTX_IO_MODE_LSB     3
`define ADTX_IO_MODE_MSB     4
`define ADTX_DELAY_SEL_BIT   5
`define ADTX_HPF_BYPASS_BIT  4
`define ADTX_LINEAR_BIT      5
`define ADTX_IO_MODE_MON     2'h2

// Reset values.
`define ADTX_MAIN_CTRL_RST   8'h01
`define ADTX_TX_GAIN_RST     3'h0
`define ADTX_DELAY_SEL_RST   1'b0
`define ADTX_CONV_MODE_RST   2'h0

// Timing: 200 MHz core clock.
`define ADTX_CLK_MHZ         200
`define ADTX_FRAME_US        125
`define ADTX_FRAME_CYC       (`ADTX_FRAME_US * `ADTX_CLK_MHZ)
`define ADTX_SEQ_KHZ         256
// Half period of the sequencing clock, rounded down.
`define ADTX_SEQ_HALF_CYC    ((`ADTX_CLK_MHZ * 1000) / (2 * `ADTX_SEQ_KHZ))
`define ADTX_DELAY_NORMAL    0
`define ADTX_DELAY_LONG      4
`define ADTX_PIPE_DEPTH      5
`endif

// *** adtx_pkg.sv ***
package adtx_pkg;
  // Encoding rate, selected by enable length.
  typedef enum logic [1:0] {
    ADTX_R16 = 2'h0,
    ADTX_R24 = 2'h1,
    ADTX_R32 = 2'h3,
    ADTX_R64 = 2'h2
  } adtx_rate_e;

  // Word handed from the encoder to the serial port.
  typedef struct packed {
    adtx_rate_e  rate;
    logic [7:0]  data;
  } adtx_word_s;

  // Settings that leave the block toward the analog side.
  typedef struct packed {
    logic [2:0]  trim_gain;
    logic        hpf_bypass;
    logic        adc_linear;
    logic        adc_sel_supply;
    logic        pump_en;
  } adtx_ana_s;

  // Enable length in bit clocks to rate; valid is low for other lengths.
  function automatic logic [2:0] adtx_len2rate(input logic [3:0] len);
    case (len)
      4'h2:    adtx_len2rate = {1'b1, ADTX_R16};
      4'h3:    adtx_len2rate = {1'b1, ADTX_R24};
      4'h4:    adtx_len2rate = {1'b1, ADTX_R32};
      4'h8:    adtx_len2rate = {1'b1, ADTX_R64};
      default: adtx_len2rate = 3'h0;
    endcase
  endfunction

  // Bits per word for a rate.
  function automatic logic [3:0] adtx_rate_bits(input adtx_rate_e r);
    case (r)
      ADTX_R16: adtx_rate_bits = 4'h2;
      ADTX_R24: adtx_rate_bits = 4'h3;
      ADTX_R32: adtx_rate_bits = 4'h4;
      default:  adtx_rate_bits = 4'h8;
    endcase
  endfunction
endpackage

// *** adtx_link_master.sv ***
`timescale 1ns/1ps
// Transmit-side master: bursts of bit clock per frame, and the enable.
module adtx_link_master (
  output logic      tx_bit_clock,
  output logic      tx_frame_enable,
  input  wire logic tx_serial_out,
  input  wire logic tx_serial_oe
);
  initial begin
    tx_bit_clock = 1'b0;
    tx_frame_enable = 1'b0;
  end

  // Free edges around reset; the clock stands still between frames.
  task automatic idle_clocks(input int n);
    repeat (n) begin
      #32 tx_bit_clock = 1'b1;
      #32 tx_bit_clock = 1'b0;
    end
  endtask

  // The word is sampled mid-high so the half-cycle drop is still counted.
  task automatic frame(input int len, output int nbits,
                       output logic [7:0] word);
    nbits = 0;
    word = 8'h00;
    #3 tx_frame_enable = 1'b1;
    for (int i = 0; i < 16; i++) begin
      #32 tx_bit_clock = 1'b1;
      #16;
      if (tx_serial_oe === 1'b1) begin
        nbits++;
        word = {word[6:0], tx_serial_out};
      end
      #16 tx_bit_clock = 1'b0;
      tx_frame_enable = (i + 1 < len);
    end
  endtask
endmodule

// *** test_adpcm_transmit_port_control.sv ***
`timescale 1ns/1ps
`include "adtx_defs.svh"
module test_adpcm_transmit_port_control
  import adtx_pkg::*;
;
  logic        ref_clk;
  logic        reset_n;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [7:0]  wb_adr;
  logic [31:0] wb_dat_w;
  logic [3:0]  wb_sel;
  logic [3:0]  sel_use;
  logic [31:0] wb_dat_r;
  logic        wb_ack;
  logic [7:0]  adc_result;
  logic        adc_valid;
  adtx_ana_s   ana_ctrl;
  logic        seq_clk;
  logic        charge_pump_clk;
  logic        tx_bit_clock;
  logic        tx_frame_enable;
  logic        tx_serial_out;
  logic        tx_serial_oe;
  logic [31:0] q;
  int          miscompares;
  int          checked;
  int          hist[$];
  int          lens[8] = '{2, 3, 4, 8, 5, 3, 2, 8};
  realtime     t0;
  logic        seen;

  adtx_port_ctrl #(.FRAME_CYC(2000)) u_dut (
    .ref_clk(ref_clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r),
    .wb_ack_o(wb_ack), .adc_result(adc_result), .adc_valid(adc_valid),
    .ana_ctrl(ana_ctrl), .seq_clk(seq_clk),
    .charge_pump_clk(charge_pump_clk), .tx_bit_clock(tx_bit_clock),
    .tx_frame_enable(tx_frame_enable), .tx_serial_out(tx_serial_out),
    .tx_serial_oe(tx_serial_oe));

  adtx_link_master u_mst (
    .tx_bit_clock(tx_bit_clock), .tx_frame_enable(tx_frame_enable),
    .tx_serial_out(tx_serial_out), .tx_serial_oe(tx_serial_oe));

  // Core clock, 200 MHz.
  initial ref_clk = 1'b0;
  always #2.5 ref_clk = ~ref_clk;

  task automatic end_of_test;
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One classic cycle; a missing ack is left to the watchdog.
  task automatic wb(input logic [7:0] a, input logic we,
                    input logic [31:0] d);
    @(posedge ref_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_sel <= sel_use;
    wb_adr <= a;
    wb_dat_w <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(a, 1'b0, 32'h0);
    chk(q, exp);
  endtask

  // One converter result, marked for a single core clock.
  task automatic adc(input logic [7:0] v);
    adc_result <= v;
    adc_valid <= 1'b1;
    @(posedge ref_clk);
    adc_valid <= 1'b0;
  endtask

  // Lengths other than 2, 3, 4 and 8 repeat the last request; words lag by d frames.
  task automatic run_frame(input int len, input int d, input bit test);
    int         n;
    int         eff;
    int         exp;
    logic [7:0] w;
    exp = hist[hist.size() - d];
    eff = (len == 2 || len == 3 || len == 4 || len == 8) ? len : hist[$];
    @(posedge ref_clk);
    u_mst.frame(len, n, w);
    if (test) chk(n, exp);
    // The very first word still holds the reset value, so it is skipped.
    if (test && hist.size() > 6) chk(w, 8'hA5 >> (8 - exp));
    hist.push_back(eff);
    repeat (8) @(posedge ref_clk);
    wb(`ADTX_STATUS_OFS, 1'b0, 32'h0);
    chk(q & 32'h3, eff == 2 ? 0 : eff == 3 ? 1 : eff == 4 ? 3 : 2);
  endtask

  // Watchdog well beyond the expected run of some 50 us.
  initial begin
    #200000;
    miscompares++;
    end_of_test;
  end

  initial begin
    reset_n = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_dat_w = 32'h0;
    wb_sel = 4'hF;
    sel_use = 4'hF;
    adc_result = 8'h00;
    adc_valid = 1'b0;
    miscompares = 0;
    checked = 0;
    hist = '{4, 4, 4, 4, 4, 4};
    // Reset is held long enough for the link side to see it too.
    fork
      u_mst.idle_clocks(6);
      repeat (80) @(posedge ref_clk);
    join
    reset_n <= 1'b1;
    u_mst.idle_clocks(4);
    rchk(`ADTX_MAIN_CTRL_OFS, 32'h01);
    rchk(`ADTX_TX_GAIN_OFS, 32'h0);
    rchk(`ADTX_TONE_DELAY_OFS, 32'h0);
    rchk(`ADTX_CONV_MODE_OFS, 32'h0);
    rchk(8'h30, 32'h0);
    chk(32'(ana_ctrl), 32'h01);
    for (int g = 0; g < 8; g++) begin
      wb(`ADTX_TX_GAIN_OFS, 1'b1, 32'(g));
      chk(32'(ana_ctrl.trim_gain), 32'(g));
    end
    // A write without byte lane 0 must leave the fields alone.
    sel_use = 4'hE;
    wb(`ADTX_TX_GAIN_OFS, 1'b1, 32'h0);
    sel_use = 4'hF;
    chk(32'(ana_ctrl.trim_gain), 32'h7);
    wb(`ADTX_CONV_MODE_OFS, 1'b1, 32'h10);
    chk({ana_ctrl.hpf_bypass, ana_ctrl.adc_linear}, 2'b10);
    wb(`ADTX_CONV_MODE_OFS, 1'b1, 32'h20);
    chk({ana_ctrl.hpf_bypass, ana_ctrl.adc_linear}, 2'b01);
    wb(`ADTX_CONV_MODE_OFS, 1'b1, 32'h00);
    wb(`ADTX_MAIN_CTRL_OFS, 1'b1, 32'h11);
    chk({ana_ctrl.adc_sel_supply, ana_ctrl.adc_linear}, 2'b11);
    adc(8'h7F);
    rchk(`ADTX_MONITOR_OFS, 32'h7F);
    wb(`ADTX_MONITOR_OFS, 1'b1, 32'h00);
    rchk(`ADTX_MONITOR_OFS, 32'h7F);
    @(posedge seq_clk);
    t0 = $realtime;
    @(posedge seq_clk);
    chk(32'(int'(($realtime - t0) / 5.0)), 2 * `ADTX_SEQ_HALF_CYC);
    #1 chk(charge_pump_clk, 1'b1);
    wb(`ADTX_MAIN_CTRL_OFS, 1'b1, 32'h10);
    seen = 1'b0;
    repeat (900) begin
      @(posedge ref_clk);
      if (charge_pump_clk !== 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b0);
    wb(`ADTX_MAIN_CTRL_OFS, 1'b1, 32'h01);
    // Speech mode: this sample feeds every word after the very first.
    adc(8'hA5);
    foreach (lens[i]) run_frame(lens[i], 2, 1'b1);
    wb(`ADTX_TONE_DELAY_OFS, 1'b1, 32'h20);
    rchk(`ADTX_TONE_DELAY_OFS, 32'h20);
    repeat (7) run_frame(8, 6, 1'b0);
    foreach (lens[i]) run_frame(lens[i], 6, 1'b1);
    // A silent link must raise the lost-frame flag.
    repeat (2500) @(posedge ref_clk);
    wb(`ADTX_STATUS_OFS, 1'b0, 32'h0);
    chk(q[2], 1'b1);
    end_of_test;
  end
endmodule
